// >>> src/gmt_link.sv
// transmit encoder on the phy transmit clock plus receive capture on the phy clock
// assumes tx_clk is a free 125 MHz clock made elsewhere and fed out to the phy
`timescale 1ns/1ps
`default_nettype none
module gmt_link (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       tx_clk,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_octet,
   input  wire logic       tx_err,
   input  wire logic       ext_req,
   input  wire logic       ext_err,
   input  wire logic       lpi_req,
   input  wire logic       rsvd_req,
   output logic            tx_en,
   output logic            tx_er,
   output logic [7:0]      txd,
   output logic            wake_done,
   output logic            int_error,
   input  wire logic       rx_clk,
   input  wire logic       rx_dv,
   input  wire logic       rx_er,
   input  wire logic [7:0] rxd,
   output logic            rx_valid,
   output logic            rx_error,
   output logic [7:0]      rx_octet,
   output logic            rx_active_sys
);
   // reset leaves each domain through two flops of its own clock,
   // so no register sees the release at a random point of its cycle
   logic [1:0]          rst_tx;
   logic [1:0]          rst_rx;
   logic [1:0]          rst_sys;
   logic                tx_rst_n;
   logic                rx_rst_n;
   logic                sys_rst_n;

   always_ff @(posedge tx_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_tx <= gmt_pkg::RESET_LEVEL;
      end else begin
         rst_tx <= {rst_tx[0], 1'b1};
      end
   end

   always_ff @(posedge rx_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_rx <= gmt_pkg::RESET_LEVEL;
      end else begin
         rst_rx <= {rst_rx[0], 1'b1};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sys <= gmt_pkg::RESET_LEVEL;
      end else begin
         rst_sys <= {rst_sys[0], 1'b1};
      end
   end

   assign tx_rst_n  = rst_tx[1];
   assign rx_rst_n  = rst_rx[1];
   assign sys_rst_n = rst_sys[1];

   // transmit state, all on tx_clk
   gmt_pkg::gmt_state_e state;
   gmt_pkg::gmt_state_e next_state;
   logic [15:0]         wake_cnt;
   logic [15:0]         next_wake_cnt;
   logic                next_wake_done;

   // extension is legal only right after data or more extension
   function automatic logic follows_data(input gmt_pkg::gmt_state_e s);
      follows_data = (s == gmt_pkg::GMT_DATA) || (s == gmt_pkg::GMT_EXT);
   endfunction

   // one encoder for both extension flavours
   function automatic logic [7:0] extend_code(input logic with_error);
      extend_code = with_error ? gmt_pkg::CODE_EXT_ERR : gmt_pkg::CODE_EXTEND;
   endfunction

   // request decode
   logic                in_frame;
   logic                in_lpi;
   logic                may_extend;
   logic                waking;
   logic                send_data;
   logic                send_ext;
   logic                send_lpi;
   logic                ext_misplaced;
   logic                rsvd_seen;

   assign in_frame      = (state == gmt_pkg::GMT_DATA);
   assign in_lpi        = (state == gmt_pkg::GMT_LPI);
   assign may_extend    = follows_data(state);
   assign waking        = (wake_cnt != 16'h0000);
   // the cycle that leaves idle mode stays quiet, then data waits out
   // the wake time; data offered meanwhile is dropped, not queued
   assign send_data     = tx_valid && !waking && !lpi_req && !in_lpi;
   assign send_ext      = !tx_valid && ext_req && may_extend;
   assign send_lpi      = !tx_valid && !send_ext && lpi_req && !in_frame;
   assign ext_misplaced = ext_req && !tx_valid && !follows_data(state);
   // reserved codes are never put on the bus, only reported
   assign rsvd_seen     = rsvd_req || ext_misplaced;

   always_comb begin
      next_state = gmt_pkg::GMT_IDLE;
      if (send_data) begin
         next_state = gmt_pkg::GMT_DATA;
      end else if (send_ext) begin
         next_state = gmt_pkg::GMT_EXT;
      end else if (send_lpi) begin
         next_state = gmt_pkg::GMT_LPI;
      end
   end

   // the wake count starts on the edge that leaves low power idle
   always_comb begin
      next_wake_cnt = waking ? wake_cnt - 16'h0001 : 16'h0000;
      unique case (state)
         gmt_pkg::GMT_LPI: begin
            if (next_state != gmt_pkg::GMT_LPI) begin
               next_wake_cnt = 16'(gmt_pkg::WAKE_CYCLES);
            end
         end
         gmt_pkg::GMT_IDLE, gmt_pkg::GMT_DATA, gmt_pkg::GMT_EXT: begin
         end
      endcase
      // low while idle mode holds or the wake time runs
      next_wake_done = (next_state != gmt_pkg::GMT_LPI) && (next_wake_cnt == 16'h0000);
   end

   // pin values for the next edge
   logic                next_tx_en;
   logic                next_tx_er;
   logic [7:0]          next_txd;
   logic [7:0]          quiet_code;

   assign quiet_code = send_lpi ? gmt_pkg::CODE_LPI : gmt_pkg::CODE_IDLE;
   assign next_tx_en = send_data;
   assign next_tx_er = (send_data && tx_err) || send_ext || send_lpi;
   assign next_txd   = send_data ? tx_octet :
                       send_ext  ? extend_code(ext_err) :
                       quiet_code;

   // control registers, held idle until the local release
   always_ff @(posedge tx_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= gmt_pkg::GMT_IDLE;
         wake_cnt <= 16'h0000;
      end else if (!tx_rst_n) begin
         state    <= gmt_pkg::GMT_IDLE;
         wake_cnt <= 16'h0000;
      end else begin
         state    <= next_state;
         wake_cnt <= next_wake_cnt;
      end
   end

   // pin registers: every change lands on a tx_clk edge
   always_ff @(posedge tx_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_en     <= 1'b0;
         tx_er     <= 1'b0;
         txd       <= gmt_pkg::CODE_IDLE;
         wake_done <= 1'b0;
         int_error <= 1'b0;
      end else if (!tx_rst_n) begin
         tx_en     <= 1'b0;
         tx_er     <= 1'b0;
         txd       <= gmt_pkg::CODE_IDLE;
         wake_done <= 1'b0;
         int_error <= 1'b0;
      end else begin
         tx_en     <= next_tx_en;
         tx_er     <= next_tx_er;
         txd       <= next_txd;
         wake_done <= next_wake_done;
         int_error <= rsvd_seen;
      end
   end

   // receive side on the phy clock; no phase relation to tx_clk is assumed
   always_ff @(posedge rx_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_error <= 1'b0;
         rx_octet <= gmt_pkg::CODE_IDLE;
      end else if (!rx_rst_n) begin
         rx_valid <= 1'b0;
         rx_error <= 1'b0;
         rx_octet <= gmt_pkg::CODE_IDLE;
      end else begin
         rx_valid <= rx_dv;
         rx_error <= rx_er;
         rx_octet <= rxd;
      end
   end

   // only a level crosses to the system clock, never a word,
   // so two plain flops are enough
   logic                rx_act_meta;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_act_meta   <= 1'b0;
         rx_active_sys <= 1'b0;
      end else begin
         rx_act_meta   <= rx_valid && sys_rst_n;
         rx_active_sys <= rx_act_meta;
      end
   end
endmodule
`default_nettype wire

// >>> src/gmt_pkg.sv
// constants shared by the gigabit media interface transmit/receive block
// assumes a 50 MHz system clock and a phy receive clock as second domain
// Functional notes
// - phy gives free-running receive clock; receive signals captured on its rising edge
// - receive and transmit clocks treated as unrelated domains
// - transmit enable rises with first preamble octet and holds for whole frame
// - transmit enable drops before edge after last data octet
// - transmit enable and data change only on transmit clock
// - enable high, error low: bus carries one octet, bit 0 least significant
// - enable low error high: 0F extend, 1F extend error, 01 lpi; both high error propagation
// - carrier extension only directly after the data portion of a frame
// - low power idle: enable low, error high, bus 0x01
// - transmit clock sourced at nominal 125 MHz, phy samples on rising edge
// - leaving lpi clears error and bus; data waits for wake-up time; code waits 850 tx_clk cycles (6.8 us), not WAKE_NS of 17000
package gmt_pkg;
   localparam logic [7:0] CODE_LPI      = 8'h01;
   localparam logic [7:0] CODE_EXTEND   = 8'h0F;
   localparam logic [7:0] CODE_EXT_ERR  = 8'h1F;
   localparam logic [7:0] CODE_IDLE     = 8'h00;
   localparam int         CLOCK_MHZ     = 50;
   localparam int         WAKE_NS       = 17000;
   localparam int         WAKE_CYCLES   = (WAKE_NS * CLOCK_MHZ + 999) / 1000;
   localparam logic [1:0] RESET_LEVEL   = 2'h0;

   typedef enum logic [1:0] {
      GMT_IDLE = 2'h0,
      GMT_DATA = 2'h1,
      GMT_EXT  = 2'h3,
      GMT_LPI  = 2'h2
   } gmt_state_e;
endpackage

// >>> tb/gmt_phy.sv
// phy model: free receive clock and framed data
// drives the receive error line itself: high when count bit 4 is set and bit 3 (data valid) is clear
`timescale 1ns/1ps
`default_nettype none
module gmt_phy (
   output logic       rx_clk,
   output logic       rx_dv,
   output logic       rx_er,
   output logic [7:0] rxd
);
   logic       clk_q = 1'b0;
   logic [7:0] count = 8'h00;
   // one fixed source, offset from the bench clocks; never switched or stretched
   initial begin
      #37;
      forever #80 clk_q = ~clk_q;
   end
   always @(posedge clk_q) count <= count + 8'h01;
   assign rx_clk = clk_q;
   assign rxd    = count;
   assign rx_dv  = count[3];
   assign rx_er  = count[4] & ~count[3];
endmodule
`default_nettype wire

// >>> tb/gmt_link_assertions.sv
// checker on gmt_link ports
// assumes tx inputs move only at tx_clk edges
`timescale 1ns/1ps
`default_nettype none
module gmt_chk (
   input wire logic       tx_clk,
   input wire logic       rx_clk,
   input wire logic       rst_n,
   input wire logic       tx_valid,
   input wire logic       tx_err,
   input wire logic       ext_req,
   input wire logic       lpi_req,
   input wire logic       rsvd_req,
   input wire logic [7:0] tx_octet,
   input wire logic       tx_en,
   input wire logic       tx_er,
   input wire logic [7:0] txd,
   input wire logic       wake_done,
   input wire logic       int_error,
   input wire logic       rx_dv,
   input wire logic       rx_er,
   input wire logic [7:0] rxd,
   input wire logic       rx_valid,
   input wire logic       rx_error,
   input wire logic [7:0] rx_octet
);
   // edges since reset left; the design holds each domain for the first two of them, the checks wait for three
   logic [1:0] tx_age;
   logic [1:0] rx_age;
   logic       go;
   logic       xt;
   logic       ext_on;
   always_ff @(posedge tx_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_age <= 2'h0;
      end else if (tx_age != 2'h3) begin
         tx_age <= tx_age + 2'h1;
      end
   end
   always_ff @(posedge rx_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_age <= 2'h0;
      end else if (rx_age != 2'h3) begin
         rx_age <= rx_age + 2'h1;
      end
   end
   assign go     = tx_valid && wake_done && !lpi_req;
   assign xt     = !tx_en && tx_er;
   assign ext_on = xt && txd != 8'h01;
   property p_tx(a, b);
      @(posedge tx_clk) disable iff (tx_age != 2'h3) a |=> b;
   endproperty
   property p_ext_place;
      @(posedge tx_clk) disable iff (tx_age != 2'h3) ext_on |-> $past(tx_en || ext_on);
   endproperty
   property p_frame_data;
      @(posedge tx_clk) disable iff (tx_age != 2'h3) go |=> tx_en && txd == $past(tx_octet);
   endproperty
   property p_rx_copy;
      @(posedge rx_clk) disable iff (rx_age != 2'h3) 1'b1 |=> rx_valid == $past(rx_dv);
   endproperty
   property p_rx_data;
      @(posedge rx_clk) disable iff (rx_age != 2'h3) 1'b1 |=> rx_octet == $past(rxd) && rx_error == $past(rx_er);
   endproperty
   a_frame_data: assert property (p_frame_data) else $error("data lost");
   a_frame_end: assert property (p_tx(!tx_valid, !tx_en)) else $error("enable stuck");
   a_err_prop: assert property (p_tx(go && tx_err, tx_er)) else $error("no error");
   a_idle_quiet: assert property (p_tx(!tx_valid && !ext_req && !lpi_req, !tx_er)) else $error("idle error");
   a_ext_place: assert property (p_ext_place) else $error("stray extend");
   a_no_rsvd: assert property (p_tx(1'b1, !xt || txd inside {8'h01, 8'h0F, 8'h1F})) else $error("reserved");
   a_rsvd_flag: assert property (p_tx(rsvd_req, int_error && !tx_er)) else $error("no flag");
   a_lpi_code: assert property (p_tx(lpi_req && !tx_valid && !ext_req, xt && txd == 8'h01)) else $error("lpi");
   a_lpi_exit: assert property (p_tx(xt && txd == 8'h01 && !lpi_req, !tx_er && txd == 8'h00)) else $error("exit");
   a_wake_hold: assert property (p_tx(!wake_done, !tx_en)) else $error("early data");
   a_rx_copy: assert property (p_rx_copy) else $error("rx copy");
   a_rx_data: assert property (p_rx_data) else $error("rx data");
   c_ext: cover property (@(posedge tx_clk) xt && txd == 8'h0F);
   c_ext_err: cover property (@(posedge tx_clk) xt && txd == 8'h1F);
   c_lpi: cover property (@(posedge tx_clk) xt && txd == 8'h01);
   c_flag: cover property (@(posedge tx_clk) int_error);
   c_wake: cover property (@(posedge tx_clk) !wake_done ##1 wake_done);
endmodule
bind gmt_link gmt_chk chk (
   .tx_clk(tx_clk),
   .rx_clk(rx_clk),
   .rst_n(rst_n),
   .tx_valid(tx_valid),
   .tx_err(tx_err),
   .ext_req(ext_req),
   .lpi_req(lpi_req),
   .rsvd_req(rsvd_req),
   .tx_octet(tx_octet),
   .tx_en(tx_en),
   .tx_er(tx_er),
   .txd(txd),
   .wake_done(wake_done),
   .int_error(int_error),
   .rx_dv(rx_dv),
   .rx_er(rx_er),
   .rxd(rxd),
   .rx_valid(rx_valid),
   .rx_error(rx_error),
   .rx_octet(rx_octet)
);
`default_nettype wire

// >>> tb/tb_gmt_link.sv
// bench for gmt_link transmit codes and receive crossing
// assumes gmt_phy drives the receive side
`timescale 1ns/1ps
`default_nettype none
module tb_gmt_link;
   logic        clock = 1'b0;
   logic        tx_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [13:0] stim = 14'h0000;
   logic        tx_en, tx_er, wake_done, int_error, rx_clk, rx_dv, rx_er, rx_act;
   logic        rx_valid, rx_error;
   logic [7:0]  txd, rxd, rx_octet;
   int          n_fail = 0;
   int          cmp_count = 0;
   wire [10:0]  seen = {int_error, tx_en, tx_er, txd};
   always #10 clock = ~clock;
   always #4 tx_clk = ~tx_clk;
   gmt_phy phy (.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));
   gmt_link dut (.clock(clock), .rst_n(rst_n), .tx_clk(tx_clk), .tx_valid(stim[13]), .tx_err(stim[12]),
      .ext_req(stim[11]), .ext_err(stim[10]), .lpi_req(stim[9]), .rsvd_req(stim[8]), .tx_octet(stim[7:0]),
      .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .wake_done(wake_done), .int_error(int_error),
      .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .rx_valid(rx_valid), .rx_error(rx_error),
      .rx_octet(rx_octet),
      .rx_active_sys(rx_act));
   task chk(input logic [10:0] s, e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %0t %h not %h", $time, s, e);
      end
   endtask
   // outputs answer the request of the step before
   task step(input logic [13:0] v, input logic [10:0] e);
      @(posedge tx_clk) stim <= v;
      #1;
      chk(seen, e);
   endtask
   task report_and_stop;
      $display("compares %0d fails %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wait_wake;
      for (int i = 0; i < 2000 && wake_done !== 1'b1; i++) @(posedge clock);
      if (wake_done !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   task wait_rx(input logic v);
      for (int i = 0; i < 2000 && rx_valid !== v; i++) @(posedge clock);
      if (rx_valid !== v) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   task t_frame;
      step(14'h2055, 11'h000);
      step(14'h30AA, 11'h255);
      step(14'h0800, 11'h3AA);
      step(14'h0C00, 11'h10F);
      step(14'h0000, 11'h11F);
   endtask
   task t_bad;
      step(14'h0800, 11'h000);
      step(14'h0100, 11'h400);
      step(14'h0000, 11'h400);
   endtask
   task t_lpi;
      step(14'h0200, 11'h000);
      step(14'h0200, 11'h101);
      step(14'h2033, 11'h101);
      step(14'h0000, 11'h000);
      chk({10'h000, wake_done}, 11'h000);
      wait_wake();
      step(14'h2033, 11'h000);
      step(14'h0000, 11'h233);
   endtask
   // each capture holds the octet the phy showed one edge before
   task t_rx;
      logic [7:0] prev;
      repeat (40) begin
         @(posedge rx_clk);
         #1;
         prev = rxd - 8'h01;
         chk({1'b0, rx_valid, rx_error, rx_octet}, {1'b0, prev[3], prev[4] & ~prev[3], prev});
      end
      wait_rx(1'b1);
      repeat (4) @(posedge clock);
      #1;
      chk({10'h000, rx_act}, 11'h001);
      wait_rx(1'b0);
      repeat (4) @(posedge clock);
      #1;
      chk({10'h000, rx_act}, 11'h000);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      repeat (30) @(posedge clock);
      t_frame();
      t_bad();
      t_lpi();
      t_rx();
      report_and_stop();
   end
endmodule
`default_nettype wire
